/* File: logic/nthc_host_cmd_regs.sv */
module nthc_host_cmd_regs
    import nthc_pkg::*;
#(
    parameter int CNT_W = 20
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // avalon-mm slave, word addressed by register index
    input wire logic [15:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [3:0] avsByteenable,
    input wire logic [31:0] avsWritedata,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    // forwarded reader command
    input wire logic cmdValid,
    input wire logic [1:0] cmdType,
    input wire logic [15:0] cmdLength,
    input wire logic [15:0] cmdOffset,
    input wire logic [15:0] cmdBufStart,
    input wire logic [CNT_W-1:0] frameWaitCycles,
    // wait extension toward the reader
    input wire logic wtxAck,
    output logic wtxValid,
    output logic [7:0] wtxByte,
    // reply toward the reader
    output logic rspValid,
    output logic [15:0] rspStatus,
    output logic [15:0] rspBufStart,
    output logic busy
);

    // maps an index onto {hit, slot}
    function automatic logic [4:0] decode_slot(input logic [15:0] a);
        logic [4:0] r;
        r = 5'h00;
        case (a)
            IDX_CSW_LO: r = {1'b1, SLOT_CSW_LO};
            IDX_CSW_HI: r = {1'b1, SLOT_CSW_HI};
            IDX_WTX_LO: r = {1'b1, SLOT_WTX_LO};
            IDX_WTX_HI: r = {1'b1, SLOT_WTX_HI};
            IDX_BUF_LO: r = {1'b1, SLOT_BUF_LO};
            IDX_BUF_HI: r = {1'b1, SLOT_BUF_HI};
            IDX_OFF_LO: r = {1'b1, SLOT_OFF_LO};
            IDX_OFF_HI: r = {1'b1, SLOT_OFF_HI};
            IDX_LEN_LO: r = {1'b1, SLOT_LEN_LO};
            IDX_LEN_HI: r = {1'b1, SLOT_LEN_HI};
            default: r = 5'h00;
        endcase
        return r;
    endfunction : decode_slot

    // reset value of each byte slot
    function automatic logic [7:0] slot_reset(input int s);
        return (s == int'(SLOT_WTX_LO)) ? WTX_RESET : BYTE_ZERO;
    endfunction : slot_reset

    // register state
    logic [7:0] bankReg [NUM_SLOTS]; // byte-wide register bank
    logic [7:0] bankNext [NUM_SLOTS];
    logic [NUM_SLOTS-1:0][7:0] hwData; // device-side load values
    logic [HR_WIDTH-1:0] hrespReg; // host response bits
    logic [HR_WIDTH-1:0] hrespNext;
    logic waitReg; // waitrequest flop
    logic [31:0] readReg; // read data flop
    nthc_state_type stateReg; // engine state
    nthc_state_type stateNext;
    logic [1:0] cmdTypeReg; // type of the pending command
    logic wtxValidReg;
    logic [7:0] wtxByteReg;
    logic rspValidReg;
    logic [15:0] rspStatusReg;
    logic [15:0] rspBufReg;
    logic busyReg;
    logic [15:0] swSel; // status word chosen for the reply
    logic [NUM_SLOTS-1:0] hwLoad; // device-side load per slot

    // timer link
    nthc_timer_if #(.CNT_W(CNT_W)) tif ();

    // bus decode
    wire busReq = avsRead || avsWrite;
    wire [4:0] dec = decode_slot(avsAddress);
    wire slotHit = dec[4];
    wire [3:0] slotIdx = dec[3:0];
    wire hrespHit = (avsAddress == IDX_HRESP_LO);
    // write lands at the edge where waitrequest is seen low
    wire wrEn = avsWrite && !waitReg && avsByteenable[0];
    wire [7:0] wrByte = avsWritedata[7:0];
    wire [7:0] slotRd = bankReg[slotIdx];
    wire [7:0] rdByte = slotHit ? slotRd :
                        hrespHit ? {HR_PAD, hrespReg} : BYTE_ZERO;

    // engine decode
    wire isIdle = (stateReg == ST_IDLE);
    wire isWaitHost = (stateReg == ST_WAIT_HOST);
    wire isWaitAck = (stateReg == ST_WAIT_ACK);
    wire cmdTake = cmdValid && isIdle;
    wire isUpdate = (cmdType == CMD_UPDATE);
    wire serviced = hrespReg[HR_SERVICED];
    wire svcTake = isWaitHost && serviced;
    wire wtxFire = isWaitHost && !serviced && tif.expired;
    wire ackTake = isWaitAck && wtxAck;
    wire hrWrite = wrEn && hrespHit;

    // device-side loads of length, offset and buffer start
    assign hwLoad[SLOT_WTX_HI:SLOT_CSW_LO] = '0; // host-only slots
    assign hwLoad[SLOT_BUF_LO] = cmdTake && isUpdate;
    assign hwLoad[SLOT_BUF_HI] = cmdTake && isUpdate;
    assign hwLoad[SLOT_OFF_LO] = cmdTake;
    assign hwLoad[SLOT_OFF_HI] = cmdTake;
    assign hwLoad[SLOT_LEN_LO] = cmdTake;
    assign hwLoad[SLOT_LEN_HI] = cmdTake;
    assign hwData[SLOT_WTX_HI:SLOT_CSW_LO] = '0; // never loaded
    assign hwData[SLOT_BUF_LO] = cmdBufStart[7:0];
    assign hwData[SLOT_BUF_HI] = cmdBufStart[15:8];
    assign hwData[SLOT_OFF_LO] = cmdOffset[7:0];
    assign hwData[SLOT_OFF_HI] = cmdOffset[15:8];
    assign hwData[SLOT_LEN_LO] = cmdLength[7:0];
    assign hwData[SLOT_LEN_HI] = cmdLength[15:8];

    // one byte flop per slot; a device load wins over a bus write
    generate
        for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
            wire busHit = wrEn && slotHit && (slotIdx == 4'(g));
            assign bankNext[g] = hwLoad[g] ? hwData[g] :
                                 busHit ? wrByte : bankReg[g];
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    bankReg[g] <= slot_reset(g);
                end else begin
                    bankReg[g] <= bankNext[g];
                end
            end
        end
    endgenerate

    // host response: host write wins over the device clearing serviced
    always_comb begin
        hrespNext = hrespReg;
        if (hrWrite) begin
            hrespNext = wrByte[HR_WIDTH-1:0];
        end else if (svcTake) begin
            hrespNext[HR_SERVICED] = 1'b0;
        end
    end

    // host response flop
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrespReg <= HR_RESET;
        end else begin
            hrespReg <= hrespNext;
        end
    end

    // bus handshake: waitrequest drops for one cycle per request
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            waitReg <= 1'b1;
            readReg <= RD_ZERO;
        end else if (busReq && waitReg) begin
            waitReg <= 1'b0;
            readReg <= {RD_PAD, rdByte};
        end else begin
            waitReg <= 1'b1;
        end
    end

    // engine next state
    always_comb begin
        stateNext = stateReg;
        case (stateReg)
            ST_IDLE: stateNext = cmdValid ? ST_WAIT_HOST : ST_IDLE;
            ST_WAIT_HOST: begin
                if (serviced) begin
                    stateNext = ST_IDLE;
                end else if (tif.expired) begin
                    stateNext = ST_WAIT_ACK;
                end
            end
            ST_WAIT_ACK: stateNext = wtxAck ? ST_WAIT_HOST : ST_WAIT_ACK;
            default: stateNext = ST_IDLE;
        endcase
    end

    // time-out runs from the command and again after each acknowledge
    assign tif.start = cmdTake || ackTake;
    assign tif.stop = svcTake;
    assign tif.limit = frameWaitCycles;

    // response time-out counter
    nthc_resp_timer #(.CNT_W(CNT_W)) u_timer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .tif(tif.timer)
    );

    // status word selection
    nthc_status_sel u_status (
        .cmdType(cmdTypeReg),
        .useCustom(hrespReg[HR_CUSTOM]),
        .fileExists(hrespReg[HR_FILE_EXISTS]),
        .customHi(bankReg[SLOT_CSW_HI]),
        .customLo(bankReg[SLOT_CSW_LO]),
        .statusWord(swSel)
    );

    // engine state and pending command type
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stateReg <= ST_IDLE;
            cmdTypeReg <= CMD_SELECT;
        end else begin
            stateReg <= stateNext;
            cmdTypeReg <= cmdTake ? cmdType : cmdTypeReg;
        end
    end

    // wait extension request toward the reader
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wtxValidReg <= 1'b0;
            wtxByteReg <= WTX_RESET;
        end else begin
            wtxValidReg <= wtxFire;
            if (wtxFire) begin
                wtxByteReg <= bankReg[SLOT_WTX_LO];
            end
        end
    end

    // reply toward the reader once the host has serviced the request
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rspValidReg <= 1'b0;
            rspStatusReg <= {BYTE_ZERO, BYTE_ZERO};
            rspBufReg <= {BYTE_ZERO, BYTE_ZERO};
            busyReg <= 1'b0;
        end else begin
            rspValidReg <= svcTake;
            if (svcTake) begin
                rspStatusReg <= swSel;
                rspBufReg <= {bankReg[SLOT_BUF_HI],
                              bankReg[SLOT_BUF_LO]};
            end
            busyReg <= (stateNext != ST_IDLE);
        end
    end

    // outputs straight from flops
    assign avsReaddata = readReg;
    assign avsWaitrequest = waitReg;
    assign wtxValid = wtxValidReg;
    assign wtxByte = wtxByteReg;
    assign rspValid = rspValidReg;
    assign rspStatus = rspStatusReg;
    assign rspBufStart = rspBufReg;
    assign busy = busyReg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_serviced;
        isWaitHost && serviced && !hrWrite;
    endsequence
    property p_len_load;
        cmdTake |=> {bankReg[SLOT_LEN_HI], bankReg[SLOT_LEN_LO]}
                    == $past(cmdLength);
    endproperty
    a_len_load: assert property (p_len_load)
        else $error("length not loaded");
    property p_off_load;
        cmdTake |=> {bankReg[SLOT_OFF_HI], bankReg[SLOT_OFF_LO]}
                    == $past(cmdOffset);
    endproperty
    a_off_load: assert property (p_off_load)
        else $error("offset not loaded");
    property p_buf_load;
        cmdTake && isUpdate |=> {bankReg[SLOT_BUF_HI],
            bankReg[SLOT_BUF_LO]} == $past(cmdBufStart);
    endproperty
    a_buf_load: assert property (p_buf_load)
        else $error("buffer start not loaded");
    property p_wtx_fire;
        wtxFire |=> wtxValidReg && isWaitAck ##1 !wtxValidReg;
    endproperty
    a_wtx_fire: assert property (p_wtx_fire)
        else $error("extension request missing");
    property p_wtx_byte;
        wtxFire |=> wtxByteReg == $past(bankReg[SLOT_WTX_LO]);
    endproperty
    a_wtx_byte: assert property (p_wtx_byte)
        else $error("extension byte wrong");
    property p_restart;
        ackTake |=> isWaitHost && tif.elapsed == '0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("time-out not restarted");
    property p_custom;
        s_serviced ##0 hrespReg[HR_CUSTOM] |=> rspValidReg && isIdle &&
            rspStatusReg == $past({bankReg[SLOT_CSW_HI],
                                   bankReg[SLOT_CSW_LO]});
    endproperty
    a_custom: assert property (p_custom)
        else $error("custom status word not used");
    property p_default;
        s_serviced ##0 !hrespReg[HR_CUSTOM] ##0 cmdTypeReg != CMD_SELECT
            |=> rspStatusReg == SW_DEFAULT_OK;
    endproperty
    a_default: assert property (p_default)
        else $error("default status word wrong");
    property p_reply_after_service;
        rspValidReg |-> $past(isWaitHost && serviced);
    endproperty
    a_reply_after_service: assert property (p_reply_after_service)
        else $error("reply without service");
    property p_bus_answer;
        busReq && waitReg |=> !waitReg ##1 waitReg;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer timing wrong");
endmodule : nthc_host_cmd_regs

/* File: logic/nthc_pkg.sv */
package nthc_pkg;
    // register indexes; the byte address is four times the index
    localparam logic [15:0] IDX_CSW_LO = 16'hffda;
    localparam logic [15:0] IDX_CSW_HI = 16'hffdb;
    localparam logic [15:0] IDX_WTX_LO = 16'hffde;
    localparam logic [15:0] IDX_WTX_HI = 16'hffdf;
    localparam logic [15:0] IDX_BUF_LO = 16'hffe4;
    localparam logic [15:0] IDX_BUF_HI = 16'hffe5;
    localparam logic [15:0] IDX_OFF_LO = 16'hffe6;
    localparam logic [15:0] IDX_OFF_HI = 16'hffe7;
    localparam logic [15:0] IDX_LEN_LO = 16'hffe8;
    localparam logic [15:0] IDX_LEN_HI = 16'hffe9;
    localparam logic [15:0] IDX_HRESP_LO = 16'hffea;
    localparam logic [15:0] IDX_HRESP_HI = 16'hffeb;
    // byte slots of the register bank
    localparam int NUM_SLOTS = 10;
    localparam logic [3:0] SLOT_CSW_LO = 4'h0;
    localparam logic [3:0] SLOT_CSW_HI = 4'h1;
    localparam logic [3:0] SLOT_WTX_LO = 4'h2;
    localparam logic [3:0] SLOT_WTX_HI = 4'h3;
    localparam logic [3:0] SLOT_BUF_LO = 4'h4;
    localparam logic [3:0] SLOT_BUF_HI = 4'h5;
    localparam logic [3:0] SLOT_OFF_LO = 4'h6;
    localparam logic [3:0] SLOT_OFF_HI = 4'h7;
    localparam logic [3:0] SLOT_LEN_LO = 4'h8;
    localparam logic [3:0] SLOT_LEN_HI = 4'h9;
    // host response bits
    localparam int HR_WIDTH = 4;
    localparam int HR_SERVICED = 0;
    localparam int HR_FILE_EXISTS = 1;
    localparam int HR_CUSTOM = 2;
    localparam logic [3:0] HR_PAD = 4'h0;
    localparam logic [HR_WIDTH-1:0] HR_RESET = 4'h0;
    // reset values
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] WTX_RESET = 8'h01;
    localparam logic [23:0] RD_PAD = 24'h000000;
    localparam logic [31:0] RD_ZERO = 32'h00000000;
    // predefined status words
    localparam logic [15:0] SW_DEFAULT_OK = 16'h9000;
    localparam logic [15:0] SW_DEFAULT_NOFILE = 16'h6a82;
    // forwarded reader commands
    typedef enum logic [1:0] {
        CMD_SELECT = 2'b00,
        CMD_READ = 2'b01,
        CMD_UPDATE = 2'b10
    } nthc_cmd_type;
    // command engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_HOST = 2'b01,
        ST_WAIT_ACK = 2'b10
    } nthc_state_type;
endpackage : nthc_pkg

/* File: logic/nthc_timer_if.sv */
// response time-out control between engine and timer
interface nthc_timer_if #(parameter int CNT_W = 20);
    logic start; // clear and run the count
    logic stop; // halt the count
    logic [CNT_W-1:0] limit; // frame waiting time in cycles
    logic expired; // one-cycle pulse at time-out
    logic [CNT_W-1:0] elapsed; // cycles counted so far
    modport ctrl(output start, output stop, output limit,
        input expired, input elapsed);
    modport timer(input start, input stop, input limit,
        output expired, output elapsed);
endinterface : nthc_timer_if

/* File: logic/nthc_resp_timer.sv */
// frame waiting time counter
module nthc_resp_timer
    import nthc_pkg::*;
#(
    parameter int CNT_W = 20
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // control from the engine
    nthc_timer_if.timer tif
);

    logic [CNT_W-1:0] countReg; // elapsed cycles
    logic runReg; // count is live
    logic expiredReg; // time-out pulse
    wire [CNT_W-1:0] countInc = countReg + 1'b1;
    wire hitLimit = (countInc >= tif.limit); // last counted cycle

    // count while running, pulse and halt at the limit
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            countReg <= '0;
            runReg <= 1'b0;
            expiredReg <= 1'b0;
        end else if (tif.start) begin
            countReg <= '0;
            runReg <= 1'b1;
            expiredReg <= 1'b0;
        end else if (tif.stop || !runReg) begin
            runReg <= 1'b0;
            expiredReg <= 1'b0;
        end else begin
            countReg <= countInc;
            runReg <= !hitLimit;
            expiredReg <= hitLimit;
        end
    end

    assign tif.expired = expiredReg;
    assign tif.elapsed = countReg;

    // time-out only after a full waiting time was counted
    property p_expire_at_limit;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(expiredReg) |-> countReg >= tif.limit;
    endproperty
    a_expire_at_limit: assert property (p_expire_at_limit)
        else $error("timer expired before limit");
endmodule : nthc_resp_timer

/* File: logic/nthc_status_sel.sv */
// status word chosen for the reply to the reader
module nthc_status_sel
    import nthc_pkg::*;
(
    // command and host choices
    input wire logic [1:0] cmdType,
    input wire logic useCustom,
    input wire logic fileExists,
    // custom word from the register bank
    input wire logic [7:0] customHi,
    input wire logic [7:0] customLo,
    // selected word
    output logic [15:0] statusWord
);

    // predefined word: a select of a missing file fails
    wire selMissing = (cmdType == CMD_SELECT) && !fileExists;
    wire [15:0] defaultWord = selMissing ? SW_DEFAULT_NOFILE
                                         : SW_DEFAULT_OK;
    // first byte from the upper half, second from the lower
    wire [15:0] customWord = {customHi, customLo};
    assign statusWord = useCustom ? customWord : defaultWord;
endmodule : nthc_status_sel

/* File: verif/nthc_host_model.sv */
// host controller that services forwarded commands over avalon-mm
module nthc_host_model
    import nthc_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // avalon-mm master side
    output logic [15:0] avsAddress,
    output logic avsRead,
    output logic avsWrite,
    output logic [3:0] avsByteenable,
    output logic [31:0] avsWritedata,
    input wire logic [31:0] avsReaddata,
    input wire logic avsWaitrequest
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle bus at time zero
    initial begin
        avsAddress = 16'h0000;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsByteenable = 4'h0;
        avsWritedata = 32'h00000000;
    end

    // one transfer; request held until waitrequest is seen low
    task automatic busOp(input logic wr, input logic [15:0] a,
        input logic [7:0] d, input logic be, output logic [31:0] q);
        @(posedge sys_clk);
        avsAddress <= a;
        avsRead <= !wr;
        avsWrite <= wr;
        avsByteenable <= {3'h0, be};
        avsWritedata <= {24'h000000, d};
        do @(posedge sys_clk); while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask : busOp

    // host reports where its read data starts in the buffer
    task automatic putBufStart(input logic [15:0] v);
        logic [31:0] q;
        busOp(1'b1, IDX_BUF_LO, v[7:0], 1'b1, q);
        busOp(1'b1, IDX_BUF_HI, v[15:8], 1'b1, q);
    endtask : putBufStart

    // answer after a chosen lag; bit 2 picks the custom word
    task automatic respond(input logic [3:0] hr, input int lag);
        logic [31:0] q;
        repeat (lag) @(posedge sys_clk);
        busOp(1'b1, IDX_HRESP_LO, {4'h0, hr}, 1'b1, q);
    endtask : respond
endmodule : nthc_host_model

/* File: verif/tb_nthc_host_cmd_regs.sv */
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
    errors++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end

// self-checking bench for the host command register bank
module tb_nthc_host_cmd_regs;
    import nthc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [1:0] typ;
        logic [15:0] len, off, cbuf, hbuf, csw;
        logic [3:0] hr;
        logic [15:0] sw;
    } nthc_row_type;

    // clock, reset, bus and command wires
    logic sys_clk, sys_rst;
    logic [15:0] avsAddress;
    logic avsRead, avsWrite, avsWaitrequest;
    logic [3:0] avsByteenable;
    logic [31:0] avsWritedata, avsReaddata;
    logic cmdValid, wtxAck, wtxValid, rspValid, busy;
    logic [1:0] cmdType;
    logic [15:0] cmdLength, cmdOffset, cmdBufStart, rspStatus, rspBufStart;
    logic [19:0] frameWaitCycles;
    logic [7:0] wtxByte;
    int errors = 0;
    int cmp_count = 0;
    logic [31:0] q;
    logic [15:0] v, eb;
    int n;
    nthc_row_type r;
    // ordinary cases: command, fields, host answer, expected status
    nthc_row_type rows [5] = '{
        '{CMD_SELECT, 16'h0000, 16'h0000, 16'h0000, 16'h1111, 16'h0000,
            4'h3, 16'h9000},
        '{CMD_SELECT, 16'h0010, 16'h0002, 16'h0000, 16'h2222, 16'h0000,
            4'h1, 16'h6a82},
        '{CMD_READ, 16'h00f0, 16'h1234, 16'h0000, 16'h0a0b, 16'h0000,
            4'h1, 16'h9000},
        '{CMD_UPDATE, 16'hff01, 16'h8000, 16'h0c0d, 16'h0000, 16'h6a80,
            4'h5, 16'h6a80},
        '{CMD_READ, 16'h0001, 16'hfffe, 16'h0000, 16'h0e0f, 16'h6281,
            4'hd, 16'h6281}
    };

    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    nthc_host_model host (.sys_clk(sys_clk), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite),
        .avsByteenable(avsByteenable), .avsWritedata(avsWritedata),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest));

    nthc_host_cmd_regs #(.CNT_W(20)) DUT (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsByteenable(avsByteenable),
        .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .cmdValid(cmdValid),
        .cmdType(cmdType), .cmdLength(cmdLength), .cmdOffset(cmdOffset),
        .cmdBufStart(cmdBufStart), .frameWaitCycles(frameWaitCycles),
        .wtxAck(wtxAck), .wtxValid(wtxValid), .wtxByte(wtxByte),
        .rspValid(rspValid), .rspStatus(rspStatus),
        .rspBufStart(rspBufStart), .busy(busy));

    // verdict and end of run
    task complete_run;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // 16-bit access as two byte transfers, low byte at even index
    task automatic wr16(input logic [15:0] a, input logic [15:0] d);
        host.busOp(1'b1, a, d[7:0], 1'b1, q);
        host.busOp(1'b1, a + 16'h0001, d[15:8], 1'b1, q);
    endtask : wr16
    task automatic rd16(input logic [15:0] a, output logic [15:0] d);
        host.busOp(1'b0, a, 8'h00, 1'b1, q);
        d[7:0] = q[7:0];
        host.busOp(1'b0, a + 16'h0001, 8'h00, 1'b1, q);
        d[15:8] = q[7:0];
    endtask : rd16

    // one-cycle forwarded command
    task automatic sendCmd(input logic [1:0] t, input logic [15:0] l, o, b);
        @(posedge sys_clk);
        cmdValid <= 1'b1;
        cmdType <= t;
        cmdLength <= l;
        cmdOffset <= o;
        cmdBufStart <= b;
        @(posedge sys_clk);
        cmdValid <= 1'b0;
    endtask : sendCmd

    // wait a bounded time for a reply or extension pulse
    task automatic waitFor(input bit wtx, output int k);
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while ((wtx ? wtxValid : rspValid) !== 1'b1 && k < 40);
    endtask : waitFor

    // whole bank reads its reset values; gaps read zero
    task automatic chkReset;
        for (logic [15:0] a = 16'hffda; a <= 16'hffeb; a++) begin
            host.busOp(1'b0, a, 8'h00, 1'b1, q);
            `CHK("reset", (a == IDX_WTX_LO) ? 32'h1 : 32'h0, q);
        end
    endtask : chkReset

    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        complete_run;
    end

    initial begin
        sys_rst = 1'b1;
        {cmdValid, wtxAck, cmdType} = 4'h0;
        {cmdLength, cmdOffset, cmdBufStart} = 48'h0;
        frameWaitCycles = 20'd1000;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        chkReset;
        `CHK("wtxrst", 8'h01, wtxByte);
        // table of ordinary commands
        for (int i = 0; i < 5; i++) begin
            r = rows[i];
            wr16(IDX_CSW_LO, r.csw);
            sendCmd(r.typ, r.len, r.off, r.cbuf);
            rd16(IDX_LEN_LO, v);
            `CHK("len", r.len, v);
            rd16(IDX_OFF_LO, v);
            `CHK("off", r.off, v);
            eb = (r.typ == CMD_UPDATE) ? r.cbuf : r.hbuf;
            if (r.typ != CMD_UPDATE) host.putBufStart(r.hbuf);
            rd16(IDX_BUF_LO, v);
            `CHK("buf", eb, v);
            host.respond(r.hr, i);
            waitFor(1'b0, n);
            `CHK("rsp", 1'b1, rspValid);
            `CHK("sw", r.sw, rspStatus);
            `CHK("rbuf", eb, rspBufStart);
        end
        // single bytes, disabled byte lane and unmapped places
        host.busOp(1'b1, IDX_CSW_HI, 8'ha5, 1'b1, q);
        host.busOp(1'b1, IDX_CSW_LO, 8'h3c, 1'b0, q);
        host.busOp(1'b1, 16'h0000, 8'h77, 1'b1, q);
        host.busOp(1'b1, IDX_HRESP_HI, 8'h77, 1'b1, q);
        rd16(IDX_CSW_LO, v);
        `CHK("bytes", 16'ha581, v);
        host.busOp(1'b0, 16'h0000, 8'h00, 1'b1, q);
        `CHK("unmap", 32'h0, q);
        host.busOp(1'b0, IDX_HRESP_HI, 8'h00, 1'b1, q);
        `CHK("hrhi", 32'h0, q);
        // second command while busy is dropped; no reply before serviced
        sendCmd(CMD_READ, 16'h0101, 16'h0202, 16'h0000);
        sendCmd(CMD_READ, 16'h0909, 16'h0808, 16'h0000);
        rd16(IDX_LEN_LO, v);
        `CHK("keep", 16'h0101, v);
        `CHK("busy", 1'b1, busy);
        host.respond(4'h4, 0);
        waitFor(1'b0, n);
        `CHK("early", 1'b0, rspValid);
        host.respond(4'h5, 2);
        waitFor(1'b0, n);
        `CHK("late", 1'b1, rspValid);
        `CHK("csw", 16'ha581, rspStatus);
        // time-out, extension byte, restart after acknowledge
        frameWaitCycles <= 20'd8;
        host.busOp(1'b1, IDX_WTX_LO, 8'h3c, 1'b1, q);
        sendCmd(CMD_UPDATE, 16'h0004, 16'h0000, 16'h0030);
        waitFor(1'b1, n);
        `CHK("wtx", 1'b1, wtxValid);
        `CHK("wtxb", 8'h3c, wtxByte);
        @(posedge sys_clk);
        wtxAck <= 1'b1;
        @(posedge sys_clk);
        wtxAck <= 1'b0;
        waitFor(1'b1, n);
        `CHK("restart", 10, n);
        @(posedge sys_clk);
        wtxAck <= 1'b1;
        @(posedge sys_clk);
        wtxAck <= 1'b0;
        host.respond(4'h1, 0);
        waitFor(1'b0, n);
        `CHK("wtxrsp", 16'h9000, rspStatus);
        `CHK("wtxbuf", 16'h0030, rspBufStart);
        // reset in the middle of a pending command
        sendCmd(CMD_READ, 16'h0011, 16'h0022, 16'h0000);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        `CHK("rstbusy", 1'b0, busy);
        `CHK("rstwtx", 8'h01, wtxByte);
        sys_rst <= 1'b0;
        chkReset;
        complete_run;
    end
endmodule : tb_nthc_host_cmd_regs
